// ===== design/sfl_defines.svh
/*
  Register offsets, field positions and reset values of the serial link control block.
  Assumes inclusion by bare name from design files only.
*/
`ifndef SFL_DEFINES_SVH
`define SFL_DEFINES_SVH
`define SFL_ADDR_HANDSHAKE   7'h01
`define SFL_ADDR_STREAM      7'h03
`define SFL_ADDR_DO_START    7'h09
`define SFL_ADDR_DO_COUNT    7'h0a
`define SFL_ADDR_READY_CTL   7'h11
`define SFL_ADDR_CSUM_CTL    7'h13
`define SFL_ADDR_CSUM_DAT    7'h1d
`define SFL_ADDR_RESULT_LOW  7'h1c
`define SFL_RST_HANDSHAKE    8'h00
`define SFL_RST_STREAM       8'h00
`define SFL_RST_DO_START     8'h1a
`define SFL_RST_DO_COUNT     8'h02
`define SFL_RST_READY_CTL    8'h03
`define SFL_RST_CSUM_CTL     8'h08
`define SFL_BIT_RELEASE      0
`define SFL_BIT_STREAM_KIND  7
`define SFL_BIT_PIN_SIX      7
`define SFL_BIT_CSUM_NO_RST  5
`define SFL_BIT_AMP_GAIN     3
`define SFL_BIT_CSUM_EN      4
`define SFL_BIT_READY_AFTER  2
`define SFL_DRV_NORMAL       3'h0
`define SFL_DRV_ALWAYS_READY 3'h3
`define SFL_DRV_DATA_ONLY    3'h4
`endif

// ===== design/sfl_link_ctrl.sv
/*
  Serial peripheral link control: register file, output pin sharing, release timing,
  data-only read setup, ready routing and checksum sequencing.
  Assumes the link clock and chip select arrive from an SPI master (mode 3) and are
  oversampled by core_clk_i; the frame is an 8-bit instruction then data bytes,
  MSB first, bit 7 of the instruction set for a read.
*/
// What this block does
// - Driver code picks data, ready or float
// - Release output after last rising edge
// - Optionally release at following falling edge
// - Stream control bit 7 picks stream kind
// - Seven-bit span for controlled streaming
// - Data-only start address, reset 0x1A
// - Data-only length is field plus one
// - Ready control bit 7 routes ready
// - Ready release resets checksum unless disabled
// - Bit 3 selects amp gain correction
// - Checksum control bit 4 enables checksum
// - Bit 2 delays ready release until checksum read
// - Checksum write resets, read returns value
// - Driver selector sits in bits 3:1
`timescale 1ns/1ps
`include "sfl_defines.svh"
module sfl_link_ctrl (
  input  wire logic             core_clk_i,
  input  wire logic             nrst_i,
  input  wire logic             sclk_i,
  input  wire logic             cs_n_i,
  input  wire logic             sdi_i,
  input  wire logic             data_ready_n_i,
  input  wire sfl_pkg::sfl_byte_type rd_data_i,
  input  wire sfl_pkg::sfl_byte_type checksum_i,
  output logic                  serial_out_o,
  output logic                  serial_out_oe_o,
  output logic                  general_pin_six_o,
  output logic                  general_pin_six_sel_o,
  output logic                  checksum_en_o,
  output logic                  checksum_clear_o,
  output logic                  stream_kind_o,
  output logic [6:0]            controlled_stream_span_o,
  output logic [6:0]            data_only_start_o,
  output logic [3:0]            result_read_bytes_o,
  output logic                  amp_gain_correction_select_o,
  output logic [6:0]            reg_addr_o,
  output logic                  reg_rd_o
);
  import sfl_pkg::*;

  logic sclk_s, cs_n_s, sdi_s, rdy_n_s;

  sfl_sync u_sync_sclk (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .rst_val_i(1'b1), .async_i(sclk_i), .sync_o(sclk_s));
  sfl_sync u_sync_cs (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .rst_val_i(1'b1), .async_i(cs_n_i), .sync_o(cs_n_s));
  sfl_sync u_sync_sdi (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .rst_val_i(1'b0), .async_i(sdi_i), .sync_o(sdi_s));
  sfl_sync u_sync_rdy (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .rst_val_i(1'b1),
                       .async_i(data_ready_n_i), .sync_o(rdy_n_s));

  sfl_state_type state_reg,       state_next;
  logic          sclk_d_reg,      sclk_d_next;
  logic          rdy_d_reg,       rdy_d_next;
  logic [2:0]    bit_cnt_reg,     bit_cnt_next;
  logic [7:0]    shift_reg,       shift_next;
  logic [7:0]    tx_reg,          tx_next;
  logic [6:0]    addr_reg,        addr_next;
  logic          read_reg,        read_next;
  logic          drive_reg,       drive_next;
  logic          hold_reg,        hold_next;
  logic          result_rd_reg,   result_rd_next;
  logic          crc_pending_reg, crc_pending_next;
  logic          clr_reg,         clr_next;
  logic          load_reg,        load_next;
  logic          rdy_out_reg,     rdy_out_next;
  logic [7:0]    hs_reg,          hs_next;
  logic [7:0]    stream_reg,      stream_next;
  logic [7:0]    do_start_reg,    do_start_next;
  logic [7:0]    do_cnt_reg,      do_cnt_next;
  logic [7:0]    rdy_ctl_reg,     rdy_ctl_next;
  logic [7:0]    csum_ctl_reg,    csum_ctl_next;
  logic          out_bit_reg,     out_bit_next;
  logic          oe_reg,          oe_next;
  logic          pin6_reg,        pin6_next;

  logic       rise, fall;
  logic [2:0] drv_code;
  logic [7:0] rd_mux;

  assign rise     = sclk_s & ~sclk_d_reg;
  assign fall     = ~sclk_s & sclk_d_reg;
  assign drv_code = hs_reg[3:1];

  always_comb begin
    unique case (addr_reg)
      `SFL_ADDR_HANDSHAKE: rd_mux = hs_reg;
      `SFL_ADDR_STREAM:    rd_mux = stream_reg;
      `SFL_ADDR_DO_START:  rd_mux = do_start_reg;
      `SFL_ADDR_DO_COUNT:  rd_mux = do_cnt_reg;
      `SFL_ADDR_READY_CTL: rd_mux = rdy_ctl_reg;
      `SFL_ADDR_CSUM_CTL:  rd_mux = csum_ctl_reg;
      `SFL_ADDR_CSUM_DAT:  rd_mux = checksum_i;
      default:             rd_mux = rd_data_i;
    endcase
  end

  always_comb begin
    state_next       = state_reg;
    sclk_d_next      = sclk_s;
    rdy_d_next       = rdy_n_s;
    bit_cnt_next     = bit_cnt_reg;
    shift_next       = shift_reg;
    tx_next          = tx_reg;
    addr_next        = addr_reg;
    read_next        = read_reg;
    drive_next       = drive_reg;
    hold_next        = hold_reg;
    result_rd_next   = result_rd_reg;
    crc_pending_next = crc_pending_reg;
    clr_next         = 1'b0;
    load_next        = 1'b0;
    rdy_out_next     = rdy_out_reg;
    hs_next          = hs_reg;
    stream_next      = stream_reg;
    do_start_next    = do_start_reg;
    do_cnt_next      = do_cnt_reg;
    rdy_ctl_next     = rdy_ctl_reg;
    csum_ctl_next    = csum_ctl_reg;

    if (cs_n_s) begin
      state_next   = SFL_ST_IDLE;
      bit_cnt_next = 3'h0;
      drive_next   = 1'b0;
      hold_next    = 1'b0;
      result_rd_next = 1'b0;
    end else begin
      if (state_reg == SFL_ST_IDLE) begin
        state_next = SFL_ST_CMD;
      end
      // Late release: a falling edge after the last rising edge ends the drive
      if (fall && hold_reg) begin
        drive_next = 1'b0;
        hold_next  = 1'b0;
      end
      if (fall && drive_reg && bit_cnt_reg != 3'h0) begin
        tx_next = {tx_reg[6:0], 1'b0};
      end
      if (rise) begin
        shift_next   = {shift_reg[6:0], sdi_s};
        bit_cnt_next = bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7) begin
          if (state_reg != SFL_ST_DATA) begin
            read_next  = shift_reg[6];
            addr_next  = {shift_reg[5:0], sdi_s};
            state_next = SFL_ST_DATA;
            if (shift_reg[6]) begin
              load_next      = 1'b1;
              result_rd_next = 1'b1;
              drive_next     = 1'b1;
            end
          end else begin
            if (!read_reg) begin
              unique case (addr_reg)
                `SFL_ADDR_HANDSHAKE: begin
                  // Forbidden driver codes are dropped
                  if ({shift_reg[2:0], sdi_s} inside {4'h0, 4'h1, 4'h6, 4'h7, 4'h8, 4'h9}) begin
                    hs_next = {shift_reg[6:0], sdi_s};
                  end else begin
                    hs_next = {shift_reg[6:3], hs_reg[3:1], sdi_s};
                  end
                end
                `SFL_ADDR_STREAM:    stream_next   = {shift_reg[6:0], sdi_s};
                `SFL_ADDR_DO_START:  do_start_next = {1'b0, shift_reg[5:0], sdi_s};
                `SFL_ADDR_DO_COUNT:  do_cnt_next   = {5'h00, shift_reg[1:0], sdi_s};
                `SFL_ADDR_READY_CTL: rdy_ctl_next  = {shift_reg[6:0], sdi_s};
                `SFL_ADDR_CSUM_CTL:  csum_ctl_next = {shift_reg[6:0], sdi_s};
                `SFL_ADDR_CSUM_DAT:  clr_next      = 1'b1;
                default: ;
              endcase
            end else begin
              if (addr_reg == `SFL_ADDR_RESULT_LOW) begin
                crc_pending_next = csum_ctl_reg[`SFL_BIT_READY_AFTER];
                rdy_out_next     = !csum_ctl_reg[`SFL_BIT_READY_AFTER] | rdy_out_reg;
              end
              if (addr_reg == `SFL_ADDR_CSUM_DAT && crc_pending_reg) begin
                crc_pending_next = 1'b0;
                rdy_out_next     = 1'b1;
              end
            end
            // Reads are single byte: its last rise ends the drive, now or at the next fall
            if (!hs_reg[`SFL_BIT_RELEASE]) begin
              drive_next = 1'b0;
            end else begin
              hold_next = 1'b1;
            end
          end
        end
      end
      // Fetch one cycle after the address settles, so outside data can follow reg_addr_o
      if (load_reg) begin
        tx_next = rd_mux;
      end
    end
    // A fresh result asserts ready and wins over a read releasing it
    if (rdy_n_s != rdy_d_reg) begin
      rdy_out_next = rdy_n_s;
    end
    // Checksum restarts when ready releases, unless suppressed
    if (rdy_out_next && !rdy_out_reg && !rdy_ctl_reg[`SFL_BIT_CSUM_NO_RST]) begin
      clr_next = 1'b1;
    end
  end

  // Pin sharing: serial data while reading, ready otherwise per driver code
  always_comb begin
    out_bit_next = rdy_out_reg;
    oe_next      = 1'b0;
    if (!cs_n_s && drive_reg && read_reg && state_reg == SFL_ST_DATA) begin
      out_bit_next = tx_reg[7];
      oe_next      = 1'b1;
    end else if (drv_code == `SFL_DRV_ALWAYS_READY) begin
      oe_next = 1'b1;
    end else if (drv_code == `SFL_DRV_NORMAL && !cs_n_s) begin
      oe_next = 1'b1;
    end
    pin6_next = rdy_out_reg;
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      state_reg       <= SFL_ST_IDLE;
      sclk_d_reg      <= 1'b1;
      rdy_d_reg       <= 1'b1;
      bit_cnt_reg     <= 3'h0;
      shift_reg       <= 8'h00;
      tx_reg          <= 8'h00;
      addr_reg        <= 7'h00;
      read_reg        <= 1'b0;
      drive_reg       <= 1'b0;
      hold_reg        <= 1'b0;
      result_rd_reg   <= 1'b0;
      crc_pending_reg <= 1'b0;
      clr_reg         <= 1'b0;
      load_reg        <= 1'b0;
      rdy_out_reg     <= 1'b1;
      hs_reg          <= `SFL_RST_HANDSHAKE;
      stream_reg      <= `SFL_RST_STREAM;
      do_start_reg    <= `SFL_RST_DO_START;
      do_cnt_reg      <= `SFL_RST_DO_COUNT;
      rdy_ctl_reg     <= `SFL_RST_READY_CTL;
      csum_ctl_reg    <= `SFL_RST_CSUM_CTL;
      out_bit_reg     <= 1'b1;
      oe_reg          <= 1'b0;
      pin6_reg        <= 1'b1;
    end else begin
      state_reg       <= state_next;
      sclk_d_reg      <= sclk_d_next;
      rdy_d_reg       <= rdy_d_next;
      bit_cnt_reg     <= bit_cnt_next;
      shift_reg       <= shift_next;
      tx_reg          <= tx_next;
      addr_reg        <= addr_next;
      read_reg        <= read_next;
      drive_reg       <= drive_next;
      hold_reg        <= hold_next;
      result_rd_reg   <= result_rd_next;
      crc_pending_reg <= crc_pending_next;
      clr_reg         <= clr_next;
      load_reg        <= load_next;
      rdy_out_reg     <= rdy_out_next;
      hs_reg          <= hs_next;
      stream_reg      <= stream_next;
      do_start_reg    <= do_start_next;
      do_cnt_reg      <= do_cnt_next;
      rdy_ctl_reg     <= rdy_ctl_next;
      csum_ctl_reg    <= csum_ctl_next;
      out_bit_reg     <= out_bit_next;
      oe_reg          <= oe_next;
      pin6_reg        <= pin6_next;
    end
  end

  assign serial_out_o                 = out_bit_reg;
  assign serial_out_oe_o              = oe_reg;
  assign general_pin_six_o            = pin6_reg;
  assign general_pin_six_sel_o        = rdy_ctl_reg[`SFL_BIT_PIN_SIX];
  assign checksum_en_o                = csum_ctl_reg[`SFL_BIT_CSUM_EN];
  assign checksum_clear_o             = clr_reg;
  assign stream_kind_o                = stream_reg[`SFL_BIT_STREAM_KIND];
  assign controlled_stream_span_o     = stream_reg[6:0];
  assign data_only_start_o            = do_start_reg[6:0];
  assign result_read_bytes_o          = {1'b0, do_cnt_reg[2:0]} + 4'h1;
  assign amp_gain_correction_select_o = rdy_ctl_reg[`SFL_BIT_AMP_GAIN];
  assign reg_addr_o                   = addr_reg;
  assign reg_rd_o                     = result_rd_reg;
endmodule

// ===== design/sfl_pkg.sv
/*
  Types shared by the serial link control block.
  Assumes the defines header is compiled alongside.
*/
package sfl_pkg;
  typedef enum logic [1:0] {
    SFL_ST_IDLE,
    SFL_ST_CMD,
    SFL_ST_DATA
  } sfl_state_type;
  typedef logic [7:0] sfl_byte_type;
endpackage

// ===== design/sfl_sync.sv
/*
  Two-flop synchroniser for one pin level.
  Assumes the input is asynchronous to core_clk_i.
*/
`timescale 1ns/1ps
module sfl_sync (
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  input  wire logic rst_val_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  always_comb begin
    meta_next = async_i;
    sync_next = meta_reg;
    if (!nrst_i) begin
      meta_next = rst_val_i;
      sync_next = rst_val_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    meta_reg <= meta_next;
    sync_reg <= sync_next;
  end

  assign sync_o = sync_reg;
endmodule

// ===== verification/sfl_link_ctrl_assertions.sv
/* Port-level checker for the serial link control block.
   Assumes a bind onto sfl_link_ctrl and one core clock domain. */
`timescale 1ns/1ps
module sfl_link_ctrl_assertions (
  input wire logic       core_clk_i,
  input wire logic       nrst_i,
  input wire logic       cs_n_i,
  input wire logic       data_ready_n_i,
  input wire logic       serial_out_o,
  input wire logic       serial_out_oe_o,
  input wire logic       checksum_clear_o,
  input wire logic       stream_kind_o,
  input wire logic [6:0] controlled_stream_span_o,
  input wire logic [6:0] data_only_start_o,
  input wire logic [3:0] result_read_bytes_o,
  input wire logic       reg_rd_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  reset_idle_a: assert property (disable iff (1'h0) !nrst_i |=> !serial_out_oe_o && serial_out_o)
    else $error("pin not idle in reset");
  reset_fields_a: assert property ($rose(nrst_i) |-> data_only_start_o == 7'h1a && result_read_bytes_o == 4'h3
    && !stream_kind_o && controlled_stream_span_o == 7'h00) else $error("field reset values wrong");
  length_range_a: assert property (result_read_bytes_o inside {[4'h1:4'h8]})
    else $error("read length out of range");
  config_hold_a: assert property (cs_n_i [*8] |=> $stable({stream_kind_o, controlled_stream_span_o,
    data_only_start_o, result_read_bytes_o})) else $error("fields changed outside a frame");
  clear_pulse_a: assert property (checksum_clear_o |=> !checksum_clear_o)
    else $error("checksum clear longer than one cycle");
  clear_cause_a: assert property ((cs_n_i && $stable(data_ready_n_i)) [*8] |-> !checksum_clear_o)
    else $error("checksum clear without cause");
  read_flag_a: assert property (cs_n_i [*6] |-> !reg_rd_o)
    else $error("read flag held while deselected");
  idle_ready_a: assert property ((cs_n_i && data_ready_n_i) [*8] ##0 serial_out_oe_o |-> serial_out_o)
    else $error("idle pin not showing ready level");
  cover property ($rose(reg_rd_o));
  cover property (checksum_clear_o);
  cover property (cs_n_i && serial_out_oe_o);
endmodule
bind sfl_link_ctrl sfl_link_ctrl_assertions chk_u (.*);

// ===== verification/sfl_link_ctrl_bench.sv
/* Self-checking bench: register model, pin sharing, release timing, ready and checksum.
   Assumes the SPI master model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
module sfl_link_ctrl_bench;
  import sfl_pkg::*;
  logic         clk = 1'h0, nrst = 1'h0, drdy_n = 1'h1;
  logic         so, oe, p6, sel, en, clr, kind, amp, rrd, mid, eo, to;
  logic [6:0]   span, start, addr;
  logic [3:0]   len;
  logic [31:0]  r;
  logic [2:0]   codes [4] = '{3'h0, 3'h3, 3'h4, 3'h5};
  sfl_byte_type csum, rv;
  wire          sclk, cs_n, sdi;
  wire          pin = oe ? so : 1'hz;
  int           err_total = 0, total_checks = 0, clr_cnt = 0, n, seed = 80;
  int           mdl [int];
  int           msk [int];
  // Outside register file answers at once, so the byte is ready when fetched
  wire sfl_byte_type rdd = ~{1'h0, addr};
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (clr === 1'h1) clr_cnt++;
  end
  sfl_link_ctrl dut_u (.core_clk_i(clk), .nrst_i(nrst), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
    .data_ready_n_i(drdy_n), .rd_data_i(rdd), .checksum_i(csum), .serial_out_o(so), .serial_out_oe_o(oe),
    .general_pin_six_o(p6), .general_pin_six_sel_o(sel), .checksum_en_o(en), .checksum_clear_o(clr),
    .stream_kind_o(kind), .controlled_stream_span_o(span), .data_only_start_o(start),
    .result_read_bytes_o(len), .amp_gain_correction_select_o(amp), .reg_addr_o(addr), .reg_rd_o(rrd));
  sfl_spi_master spi_u (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .pin_i(pin));
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    spi_u.xfer({1'h0, a, d}, 1'h0, rv, mid, eo, to);
    if (a == 7'h01 && !(d[3:1] inside {3'h0, 3'h3, 3'h4})) d[3:1] = 3'(mdl[1] >> 1);
    if (mdl.exists(a)) mdl[a] = d;
  endtask
  task automatic rdc(input logic [6:0] a);
    logic [7:0] m;
    logic [7:0] e;
    m = mdl.exists(a) ? 8'(msk[a]) : 8'hff;
    e = mdl.exists(a) ? 8'(mdl[a]) : (a == 7'h1d ? csum : ~{1'h0, a});
    spi_u.xfer({1'h1, a, 8'h00}, 1'h0, rv, mid, eo, to);
    chk("read", e & m, rv & m);
  endtask
  task automatic ports();
    chk("stream", 8'(mdl[3]), {kind, span});
    chk("start", 8'(mdl[9] & 8'h7f), {1'h0, start});
    chk("length", 8'((mdl[10] & 7) + 1), {4'h0, len});
    chk("flags", 8'({mdl[17][7], mdl[17][3], mdl[19][4]}), {5'h0, sel, amp, en});
  endtask
  // Last data bit and ready level are both high, so only the drive state can differ
  task automatic frame();
    int c;
    c = (mdl[1] >> 1) & 7;
    spi_u.xfer(16'ha000, 1'h1, rv, mid, eo, to);
    chk("data", 8'hdf, rv);
    chk("mid", {7'h0, c == 4 ? 1'hz : 1'h1}, {7'h0, mid});
    chk("end", {7'h0, c == 4 && (mdl[1] & 1) == 0 ? 1'hz : 1'h1}, {7'h0, eo});
    chk("tail", {7'h0, c == 4 ? 1'hz : 1'h1}, {7'h0, to});
    chk("idle", {7'h0, c == 3 ? 1'h1 : 1'hz}, {7'h0, pin});
  endtask
  task automatic drdy(input logic v);
    @(negedge clk);
    drdy_n = v;
    repeat (8) @(negedge clk);
  endtask
  initial begin
    #300000;
    err_total++;
    print_verdict();
  end
  initial begin
    csum = 8'($random(seed));
    mdl = '{1: 8'h00, 3: 8'h00, 9: 8'h1a, 10: 8'h02, 17: 8'h03, 19: 8'h08};
    msk = '{1: 8'h0f, 3: 8'hff, 9: 8'h7f, 10: 8'h07, 17: 8'haf, 19: 8'h1c};
    repeat (8) @(negedge clk);
    nrst = 1'h1;
    repeat (4) @(negedge clk);
    foreach (mdl[a]) rdc(7'(a));
    rdc(7'h20);
    rdc(7'h1d);
    ports();
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      wr(7'h03, r[7:0]);
      wr(7'h09, r[15:8]);
      wr(7'h0a, r[23:16]);
      wr(7'h11, (r[31:24] & 8'ha8) | 8'h03);
      wr(7'h13, (r[7:0] & 8'h14) | 8'h08);
      wr(7'h01, {4'h0, codes[i % 4], i[2]});
      foreach (mdl[a]) rdc(7'(a));
      ports();
      frame();
    end
    wr(7'h11, 8'h83);
    wr(7'h13, 8'h08);
    drdy(1'h0);
    chk("pin6", 8'h00, {7'h0, p6});
    n = clr_cnt;
    rdc(7'h1c);
    chk("pin6", 8'h01, {7'h0, p6});
    chk("cleared", 8'h01, {7'h0, clr_cnt > n});
    drdy(1'h1);
    wr(7'h13, 8'h0c);
    drdy(1'h0);
    rdc(7'h1c);
    chk("pin6", 8'h00, {7'h0, p6});
    rdc(7'h1d);
    chk("pin6", 8'h01, {7'h0, p6});
    drdy(1'h1);
    wr(7'h11, 8'ha3);
    n = clr_cnt;
    drdy(1'h0);
    drdy(1'h1);
    chk("cleared", 8'h00, {7'h0, clr_cnt > n});
    wr(7'h1d, 8'h55);
    chk("cleared", 8'h01, {7'h0, clr_cnt > n});
    print_verdict();
  end
endmodule

// ===== verification/sfl_spi_master.sv
/* SPI master model, mode 3: clock idles high, 48 ns period, MSB first.
   Assumes the bench calls xfer and feeds back the resolved output pin. */
`timescale 1ns/1ps
module sfl_spi_master (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o,
  input  wire logic pin_i
);
  initial begin
    sclk_o = 1'h1;
    cs_n_o = 1'h1;
    sdi_o = 1'h0;
  end
  // Tail gives one stray falling edge after the last byte; a partial byte is dropped
  task automatic xfer(input logic [15:0] sh, input logic tail, output logic [7:0] rd,
                      output logic mid, output logic eo, output logic to);
    cs_n_o = 1'h0;
    #24;
    for (int i = 15; i >= 0; i--) begin
      sclk_o = 1'h0;
      sdi_o = sh[i];
      #24;
      sclk_o = 1'h1;
      if (i < 8) rd[i] = pin_i;
      if (i == 12) mid = pin_i;
      #24;
    end
    #16;
    eo = pin_i;
    sclk_o = !tail;
    #40;
    to = pin_i;
    sclk_o = 1'h1;
    #24;
    cs_n_o = 1'h1;
    #48;
  endtask
endmodule
